/* src/mcae_consts.vh */
// constants for the move and carry-add execute block
// assumes 14-bit instruction words and a 16-bit data address space
`ifndef MCAE_CONSTS_VH
`define MCAE_CONSTS_VH

// ----------------------------------------------------------------
// instruction encodings, matched on the top bits of the word
// ----------------------------------------------------------------
`define MCAE_ENC_ADDC6     6'h3D
`define MCAE_ENC_WLIT6     6'h30
`define MCAE_ENC_WSTORE7   7'h01
`define MCAE_ENC_PLIT7     7'h63
`define MCAE_ENC_IOFS7     7'h7E
`define MCAE_ENC_BLIT9     9'h001
`define MCAE_ENC_IMODE11   11'h002

// ----------------------------------------------------------------
// pointer update modes
// ----------------------------------------------------------------
`define MCAE_MODE_PREINC   2'h0
`define MCAE_MODE_PREDEC   2'h1
`define MCAE_MODE_POSTINC  2'h2
`define MCAE_MODE_POSTDEC  2'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MCAE_DEST_BIT      7
`define MCAE_MODE_SEL_BIT  2
`define MCAE_OFS_SEL_BIT   6
`define MCAE_OFS_SIGN_BIT  5

// ----------------------------------------------------------------
// indirect data port file addresses
// ----------------------------------------------------------------
`define MCAE_IND_PORT0     7'h00
`define MCAE_IND_PORT1     7'h01

// ----------------------------------------------------------------
// reset values and pointer step
// ----------------------------------------------------------------
`define MCAE_RST_W         8'h00
`define MCAE_RST_BANK      5'h00
`define MCAE_RST_PROGRAM_COUNTER_LATCH_HIGH    7'h00
`define MCAE_RST_PTR       16'h0000
`define MCAE_PTR_STEP      16'h0001

`endif

/* src/mcae_addc.v */
// add-with-carry unit: sum, carry, digit carry and zero
// purely combinational, used by the execute core
`timescale 1ns/1ps
module mcae_addc (
	input  wire [7:0] a_in,
	input  wire [7:0] b_in,
	input  wire       cin_in,
	output wire [7:0] sum_out,
	output wire       carry_out,
	output wire       dc_out,
	output wire       zero_out
);
	wire [8:0] full;
	wire [4:0] low;

	assign full      = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin_in};
	assign low       = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
	assign sum_out   = full[7:0];
	assign carry_out = full[8];
	assign dc_out    = low[4];
	assign zero_out  = (full[7:0] == 8'h00);
endmodule // mcae_addc

/* src/mcae_core.v */
// execute core for a subset of an 8-bit instruction set
// assumes fetch and data memory on mclk_in; memory read data valid
// in the cycle after mem_re_out is sampled high
`timescale 1ns/1ps
`include "mcae_consts.vh"
module mcae_core (
	input  wire        mclk_in,
	input  wire        reset_n_in,
	input  wire        ce_in,
	input  wire [13:0] instr_in,
	input  wire        instr_valid_in,
	output wire        instr_ready_out,
	output wire        busy_out,
	output wire [15:0] mem_addr_out,
	output wire [7:0]  mem_wdata_out,
	output wire        mem_we_out,
	output wire        mem_re_out,
	input  wire [7:0]  mem_rdata_in,
	output wire [7:0]  w_out,
	output wire        carry_out,
	output wire        dc_out,
	output wire        zero_out,
	output wire [4:0]  bank_select_register_out,
	output wire [6:0]  program_counter_latch_high_out,
	output wire [15:0] fsp0_out,
	output wire [15:0] fsp1_out
);
	// ----------------------------------------------------------------
	// states and operation classes
	// ----------------------------------------------------------------
	localparam [1:0] S_IDLE  = 2'h0;
	localparam [1:0] S_STALL = 2'h1;
	localparam [1:0] S_READ  = 2'h2;
	localparam [1:0] S_WB    = 2'h3;

	localparam [2:0] OP_NONE  = 3'h0;
	localparam [2:0] OP_ADDC  = 3'h1;
	localparam [2:0] OP_IMODE = 3'h2;
	localparam [2:0] OP_IOFS  = 3'h3;
	localparam [2:0] OP_BLIT  = 3'h4;
	localparam [2:0] OP_PLIT  = 3'h5;
	localparam [2:0] OP_WLIT  = 3'h6;
	localparam [2:0] OP_WSTR  = 3'h7;

	function [2:0] decode_op;
		input [13:0] ins;
		begin
			if (ins[13:8] == `MCAE_ENC_ADDC6)
				decode_op = OP_ADDC;
			else if (ins[13:3] == `MCAE_ENC_IMODE11)
				decode_op = OP_IMODE;
			else if (ins[13:7] == `MCAE_ENC_IOFS7)
				decode_op = OP_IOFS;
			else if (ins[13:5] == `MCAE_ENC_BLIT9)
				decode_op = OP_BLIT;
			else if (ins[13:7] == `MCAE_ENC_PLIT7)
				decode_op = OP_PLIT;
			else if (ins[13:8] == `MCAE_ENC_WLIT6)
				decode_op = OP_WLIT;
			else if (ins[13:7] == `MCAE_ENC_WSTORE7)
				decode_op = OP_WSTR;
			else
				decode_op = OP_NONE;
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [1:0]  state_q;
	reg [13:0] instr_q;
	reg [7:0]  w_q;
	reg        c_q;
	reg        dc_q;
	reg        z_q;
	reg [4:0]  bank_q;
	reg [6:0]  program_counter_latch_high_q;
	reg [15:0] fsp0_q;
	reg [15:0] fsp1_q;
	reg [15:0] addr_q;
	reg [7:0]  wdata_q;
	reg        we_q;
	reg        re_q;

	// ----------------------------------------------------------------
	// decode and address generation
	// ----------------------------------------------------------------
	wire        idle    = (state_q == S_IDLE);
	wire        accept  = idle & instr_valid_in & ce_in;
	wire [13:0] cur     = idle ? instr_in : instr_q;
	wire [2:0]  op      = decode_op(cur);
	wire [2:0]  op_q    = decode_op(instr_q);
	wire [6:0]  file_a  = cur[6:0];
	wire [1:0]  mode    = cur[1:0];
	wire        f_ind   = (file_a == `MCAE_IND_PORT0) | (file_a == `MCAE_IND_PORT1);
	wire [15:0] f_ptr   = file_a[0] ? fsp1_q : fsp0_q;
	wire        sel     = (op == OP_IMODE) ? cur[`MCAE_MODE_SEL_BIT] : cur[`MCAE_OFS_SEL_BIT];
	wire [15:0] ptr     = sel ? fsp1_q : fsp0_q;
	wire [15:0] ptr_inc = ptr + `MCAE_PTR_STEP;
	wire [15:0] ptr_dec = ptr - `MCAE_PTR_STEP;
	wire [15:0] ofs     = {{10{cur[`MCAE_OFS_SIGN_BIT]}}, cur[5:0]};
	wire [15:0] ptr_new = mode[0] ? ptr_dec : ptr_inc;
	reg  [15:0] eff;

	always @* begin
		if (op == OP_IMODE) begin
			if (mode == `MCAE_MODE_PREINC)
				eff = ptr_inc;
			else if (mode == `MCAE_MODE_PREDEC)
				eff = ptr_dec;
			else
				eff = ptr;
		end else if (op == OP_IOFS) begin
			eff = ptr + ofs;
		end else if (f_ind) begin
			eff = f_ptr;
		end else begin
			eff = {4'h0, bank_q, file_a};
		end
	end

	wire is_read  = (op == OP_ADDC) | (op == OP_IMODE) | (op == OP_IOFS);
	wire indirect = (op == OP_IMODE) | (op == OP_IOFS) |
	                (((op == OP_ADDC) | (op == OP_WSTR)) & f_ind);
	wire stall    = indirect & eff[15];
	wire issue    = (accept & ~stall) | ((state_q == S_STALL) & ce_in);

	// ----------------------------------------------------------------
	// add with carry
	// ----------------------------------------------------------------
	wire [7:0] sum;
	wire       sum_c;
	wire       sum_dc;
	wire       sum_z;

	mcae_addc u_addc (
		.a_in      (w_q),
		.b_in      (mem_rdata_in),
		.cin_in    (c_q),
		.sum_out   (sum),
		.carry_out (sum_c),
		.dc_out    (sum_dc),
		.zero_out  (sum_z)
	);

	// ----------------------------------------------------------------
	// sequencing and execution
	// ----------------------------------------------------------------
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q  <= S_IDLE;
			instr_q  <= 14'h0000;
			w_q      <= `MCAE_RST_W;
			c_q      <= 1'b0;
			dc_q     <= 1'b0;
			z_q      <= 1'b0;
			bank_q   <= `MCAE_RST_BANK;
			program_counter_latch_high_q <= `MCAE_RST_PROGRAM_COUNTER_LATCH_HIGH;
			fsp0_q   <= `MCAE_RST_PTR;
			fsp1_q   <= `MCAE_RST_PTR;
			addr_q   <= 16'h0000;
			wdata_q  <= 8'h00;
			we_q     <= 1'b0;
			re_q     <= 1'b0;
		end else if (ce_in) begin
			we_q <= 1'b0;
			re_q <= 1'b0;
			if (accept)
				instr_q <= instr_in;
			case (state_q)
			S_IDLE: begin
				if (accept & stall)
					state_q <= S_STALL;
				else if (accept & is_read)
					state_q <= S_READ;
			end
			S_STALL: begin
				state_q <= is_read ? S_READ : S_IDLE;
			end
			S_READ: begin
				state_q <= S_WB;
			end
			default: begin
				state_q <= S_IDLE;
				if (op_q == OP_ADDC) begin
					c_q  <= sum_c;
					dc_q <= sum_dc;
					z_q  <= sum_z;
					if (instr_q[`MCAE_DEST_BIT]) begin
						we_q    <= 1'b1;
						wdata_q <= sum;
					end else begin
						w_q <= sum;
					end
				end else begin
					w_q <= mem_rdata_in;
					z_q <= (mem_rdata_in == 8'h00);
				end
			end
			endcase
			if (issue) begin
				case (op)
				OP_BLIT: bank_q <= cur[4:0];
				OP_PLIT: program_counter_latch_high_q <= cur[6:0];
				OP_WLIT: w_q <= cur[7:0];
				OP_WSTR: begin
					we_q    <= 1'b1;
					addr_q  <= eff;
					wdata_q <= w_q;
				end
				OP_IMODE: begin
					re_q   <= 1'b1;
					addr_q <= eff;
					if (sel)
						fsp1_q <= ptr_new;
					else
						fsp0_q <= ptr_new;
				end
				OP_ADDC, OP_IOFS: begin
					re_q   <= 1'b1;
					addr_q <= eff;
				end
				default: begin
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign instr_ready_out                = idle;
	assign busy_out                       = ~idle;
	assign mem_addr_out                   = addr_q;
	assign mem_wdata_out                  = wdata_q;
	assign mem_we_out                     = we_q;
	assign mem_re_out                     = re_q;
	assign w_out                          = w_q;
	assign carry_out                      = c_q;
	assign dc_out                         = dc_q;
	assign zero_out                       = z_q;
	assign bank_select_register_out       = bank_q;
	assign program_counter_latch_high_out = program_counter_latch_high_q;
	assign fsp0_out                       = fsp0_q;
	assign fsp1_out                       = fsp1_q;
endmodule // mcae_core

/* verif/mcae_core_sva.sv */
// assertions on the execute core ports
// assumes a bind to mcae_core from the bench top file
`timescale 1ns/1ps
module mcae_core_sva (
	input wire        mclk_in,
	input wire        reset_n_in,
	input wire        ce_in,
	input wire [13:0] instr_in,
	input wire        instr_valid_in,
	input wire        instr_ready_out,
	input wire [15:0] mem_addr_out,
	input wire [7:0]  mem_wdata_out,
	input wire        mem_we_out,
	input wire        mem_re_out,
	input wire [7:0]  w_out,
	input wire        carry_out,
	input wire        zero_out,
	input wire [4:0]  bank_select_register_out,
	input wire [6:0]  program_counter_latch_high_out,
	input wire [15:0] fsp0_out,
	input wire [15:0] fsp1_out
);
	// ----
	// checks
	// ----
	wire        acc = instr_valid_in & instr_ready_out & ce_in;
	wire [13:0] ins = instr_in;
	reg  [13:0] ins_q;
	reg  [15:0] exp0_q;
	// address a mode-form access on pointer 0 will use, for the stall case
	wire [15:0] m_eff = ins[1] ? fsp0_out : (ins[0] ? fsp0_out - 16'h0001 : fsp0_out + 16'h0001);
	always @(posedge mclk_in) ins_q <= instr_in;
	always @(posedge mclk_in) begin
		if (acc)
			exp0_q <= ins[0] ? fsp0_out - 16'h0001 : fsp0_out + 16'h0001;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	wlit_load_a: assert property (acc && ins[13:8] == 6'h30 |=> w_out == ins_q[7:0]
		&& $stable(zero_out) && $stable(carry_out)) else $error("w literal load wrong");
	blit_load_a: assert property (acc && ins[13:5] == 9'h001 |=>
		bank_select_register_out == ins_q[4:0] && $stable(zero_out)) else $error("bank load wrong");
	plit_load_a: assert property (acc && ins[13:7] == 7'h63 |=>
		program_counter_latch_high_out == ins_q[6:0] && $stable(carry_out))
		else $error("latch load wrong");
	store_write_a: assert property (acc && ins[13:7] == 7'h01 && ins[6:1] != 6'h00 |=>
		mem_we_out && mem_wdata_out == w_out
		&& mem_addr_out == {4'h0, bank_select_register_out, ins_q[6:0]}) else $error("store wrong");
	ofs_keep_a: assert property (acc && ins[13:7] == 7'h7E |=>
		$stable(fsp0_out) && $stable(fsp1_out)) else $error("offset form moved pointer");
	mode_step_a: assert property (acc && ins[13:3] == 11'h002 && !ins[2] && !m_eff[15]
		|=> fsp0_out == exp0_q) else $error("pointer step wrong");
	mode_stall_a: assert property (acc && ins[13:3] == 11'h002 && !ins[2] && m_eff[15]
		|=> $stable(fsp0_out) ##1 fsp0_out == exp0_q) else $error("stalled pointer step wrong");
	read_strobe_a: assert property (acc && (ins[13:3] == 11'h002 || ins[13:7] == 7'h7E)
		|-> ##[1:2] mem_re_out) else $error("no read strobe");
	addc_zero_a: assert property (acc && ins[13:7] == 7'h7A && ins[6:1] != 6'h00 |->
		##3 instr_ready_out && zero_out == (w_out == 8'h00)) else $error("add zero flag wrong");
	cover property (acc && ins[13:8] == 6'h3D);
	cover property (acc && ins[13:7] == 7'h7E);
	cover property (mem_we_out);
endmodule // mcae_core_sva

/* verif/mcae_mem_model.sv */
// data memory model facing the execute core
// assumes read data wanted in the cycle after the strobe edge
`timescale 1ns/1ps
module mcae_mem_model (
	input  wire        mclk_in,
	input  wire [15:0] addr_in,
	input  wire [7:0]  wdata_in,
	input  wire        we_in,
	input  wire        re_in,
	output reg  [7:0]  rdata_out
);
	// ----
	// storage
	// ----
	reg [7:0] mem [0:4095];
	initial rdata_out = 8'h00;
	always @(posedge mclk_in) begin
		if (we_in)
			mem[addr_in[11:0]] <= wdata_in;
		// data only after a strobe, churn otherwise
		rdata_out <= re_in ? mem[addr_in[11:0]] : ~rdata_out;
	end
endmodule // mcae_mem_model

/* verif/mcae_core_tb.sv */
// self-checking bench for the execute core
// assumes mcae_core, mcae_mem_model and mcae_core_sva compiled
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module mcae_core_tb;
	reg         mclk_in = 0;
	reg         reset_n_in = 0;
	reg  [13:0] instr_in = 14'h0000;
	reg         instr_valid_in = 0;
	reg         ce_in = 1;
	logic       busy_seen;
	wire        instr_ready_out, mem_we_out, mem_re_out, carry_out, dc_out, zero_out, busy_out;
	wire [15:0] mem_addr_out, fsp0_out, fsp1_out;
	wire [7:0]  mem_wdata_out, mem_rdata_in, w_out;
	wire [4:0]  bank_select_register_out;
	wire [6:0]  program_counter_latch_high_out;
	int         bad_count = 0, total_checks = 0, cycles = 0, n;
	always #12.5 mclk_in = ~mclk_in;
	mcae_core i_mcae_core (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
		.instr_in(instr_in), .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out),
		.busy_out(busy_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_we_out(mem_we_out), .mem_re_out(mem_re_out), .mem_rdata_in(mem_rdata_in),
		.w_out(w_out), .carry_out(carry_out), .dc_out(dc_out), .zero_out(zero_out),
		.bank_select_register_out(bank_select_register_out),
		.program_counter_latch_high_out(program_counter_latch_high_out),
		.fsp0_out(fsp0_out), .fsp1_out(fsp1_out));
	mcae_mem_model i_mcae_mem_model (.mclk_in(mclk_in), .addr_in(mem_addr_out),
		.wdata_in(mem_wdata_out), .we_in(mem_we_out), .re_in(mem_re_out), .rdata_out(mem_rdata_in));
	// ----
	// tasks
	// ----
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// accept, then count cycles until ready again
	task issue(input [13:0] c);
		instr_in = c;
		instr_valid_in = 1;
		@(posedge mclk_in) #1;
		instr_valid_in = 0;
		busy_seen = busy_out;
		n = 0;
		do begin
			@(posedge mclk_in) #1;
			n++;
		end while (instr_ready_out !== 1'b1 && n < 50);
	endtask
	task t_literals;
		issue(14'h003F);
		`CHK(bank_select_register_out, 5'h1F)
		issue(14'h31FF);
		`CHK(program_counter_latch_high_out, 7'h7F)
		issue(14'h3000);
		`CHK(w_out, 8'h00)
		`CHK(zero_out, 1'b0)
		`CHK(n, 1)
		`CHK(busy_seen, 1'b0)
		issue(14'h0020);
	endtask
	// clock enable low must hold off the accept
	task t_enable;
		ce_in = 0;
		instr_in = 14'h305A;
		instr_valid_in = 1;
		@(posedge mclk_in) #1;
		`CHK(w_out, 8'h00)
		ce_in = 1;
		@(posedge mclk_in) #1;
		instr_valid_in = 0;
		`CHK(w_out, 8'h5A)
		`CHK(zero_out, 1'b1)
	endtask
	task t_store;
		issue(14'h304F);
		issue(14'h00A5);
		`CHK(n, 1)
		issue(14'h0081);
		`CHK(i_mcae_mem_model.mem[12'h025], 8'h4F)
		@(posedge mclk_in) #1;
		`CHK(i_mcae_mem_model.mem[12'h000], 8'h4F)
	endtask
	task t_addc;
		i_mcae_mem_model.mem[12'h030] = 8'hF0;
		i_mcae_mem_model.mem[12'h031] = 8'h0F;
		issue(14'h3010);
		issue(14'h3D30);
		`CHK({w_out, carry_out, dc_out, zero_out}, 11'h005)
		`CHK(busy_seen, 1'b1)
		`CHK(n, 2)
		issue(14'h3DB1);
		@(posedge mclk_in) #1;
		`CHK({w_out, carry_out, dc_out, zero_out}, 11'h002)
		`CHK(i_mcae_mem_model.mem[12'h031], 8'h10)
	endtask
	task t_modes;
		logic [1:0]  md [4];
		logic [15:0] ep [4];
		logic [7:0]  ew [4];
		md = '{2'h0, 2'h3, 2'h1, 2'h2};
		ep = '{16'h0001, 16'h0000, 16'hFFFF, 16'h0000};
		ew = '{8'h11, 8'h11, 8'h00, 8'h00};
		i_mcae_mem_model.mem[12'h001] = 8'h11;
		i_mcae_mem_model.mem[12'hFFF] = 8'h00;
		for (int k = 0; k < 4; k++) begin
			issue({11'h002, 1'b0, md[k]});
			`CHK(fsp0_out, ep[k])
			`CHK(w_out, ew[k])
			`CHK(zero_out, ew[k] == 8'h00)
			`CHK(n, (k < 2) ? 2 : 3)
		end
	endtask
	task t_offset;
		i_mcae_mem_model.mem[12'hFFF] = 8'h5A;
		i_mcae_mem_model.mem[12'h01F] = 8'h33;
		issue({7'h7E, 1'b1, 6'h3F});
		`CHK({w_out, fsp1_out}, 24'h5A_0000)
		`CHK(n, 3)
		issue({7'h7E, 1'b1, 6'h1F});
		`CHK({w_out, fsp1_out}, 24'h33_0000)
	endtask
	// ----
	// sequence
	// ----
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (3) @(posedge mclk_in);
		#1 reset_n_in = 1;
		t_literals;
		t_store;
		t_addc;
		t_modes;
		t_enable;
		t_offset;
		give_verdict;
	end
endmodule // mcae_core_tb
bind mcae_core mcae_core_sva i_mcae_core_sva (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
	.ce_in(ce_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
	.instr_ready_out(instr_ready_out), .mem_addr_out(mem_addr_out),
	.mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out), .mem_re_out(mem_re_out),
	.w_out(w_out), .carry_out(carry_out), .zero_out(zero_out),
	.bank_select_register_out(bank_select_register_out),
	.program_counter_latch_high_out(program_counter_latch_high_out),
	.fsp0_out(fsp0_out), .fsp1_out(fsp1_out));
